/* File: verilog/asm_pack_pkg.sv */
// Constants and carrier types for the drive status assembly packer
package asm_pack_pkg;

    // Producing instance numbers
    localparam logic [7:0] INST_BASIC     = 8'h46;
    localparam logic [7:0] INST_EXT       = 8'h47;
    localparam logic [7:0] INST_TORQ      = 8'h48;
    localparam logic [7:0] INST_EXT_TORQ  = 8'h49;

    // Payload lengths in bytes
    localparam logic [2:0] LEN_SHORT      = 3'h4;
    localparam logic [2:0] LEN_LONG       = 3'h6;
    localparam logic [2:0] LEN_NONE       = 3'h0;

    // Flag bit positions in byte 0
    localparam int FLAG_FAULTED_POS   = 0;
    localparam int FLAG_WARNING_POS   = 1;
    localparam int FLAG_RUN_FWD_POS   = 2;
    localparam int FLAG_RUN_REV_POS   = 3;
    localparam int FLAG_READY_POS     = 4;
    localparam int FLAG_CTRL_NET_POS  = 5;
    localparam int FLAG_REF_NET_POS   = 6;
    localparam int FLAG_REACHED_POS   = 7;

    // Register byte addresses
    localparam logic [4:0] REG_CTRL       = 5'h00;
    localparam logic [4:0] REG_STATUS     = 5'h04;
    localparam logic [4:0] REG_IRQ_STAT   = 5'h08;
    localparam logic [4:0] REG_IRQ_MASK   = 5'h0C;
    localparam logic [4:0] REG_PAYLOAD_LO = 5'h10;
    localparam logic [4:0] REG_PAYLOAD_HI = 5'h14;

    // Register fields
    localparam int CTRL_BUILD_POS     = 8;
    localparam int STATUS_ERR_POS     = 8;
    localparam int PAYLOAD_LEN_LSB    = 16;
    localparam int IRQ_DONE_POS       = 0;
    localparam int IRQ_BAD_POS        = 1;
    localparam int IRQ_WIDTH          = 2;

    // Reset values
    localparam logic [7:0] CTRL_INST_RST  = 8'h46;
    localparam logic [1:0] IRQ_MASK_RST   = 2'h0;

    typedef struct packed {
        logic        speed_reached_flag;
        logic        ref_net_flag;
        logic        ctrl_net_flag;
        logic        ready_flag;
        logic        running_reverse_flag;
        logic        running_forward_flag;
        logic        warning_flag;
        logic        faulted_flag;
        logic [7:0]  drive_state;
        logic [15:0] speed_actual;
        logic [15:0] torque_actual;
    } drive_status_t;

    typedef struct packed {
        logic [5:0][7:0] bytes;
        logic [2:0]      len;
    } payload_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_t;

endpackage

/* File: verilog/drive_status_assembly_packer.sv */
// Drive status assembly packer with Avalon-MM register slave
// Contract
// - Offer producing instances 70 to 73; requested number picks the layout.
// - Instance 70: four bytes, fault bit 0, forward bit 2, byte 1 zero.
// - Speed word goes low byte in byte 2, high byte in byte 3.
// - Instance 71 byte 0 holds the eight flags, reached at bit 7.
// - Extended layouts carry the drive state code in byte 1.
// - Instance 72: six bytes, first four as instance 70, then torque.
// - Torque word goes low byte in byte 4, high byte in byte 5.
// - Instance 73: extended flags, drive state, speed in bytes 2 and 3.
// - Instance 73 appends torque after speed, giving six bytes.
//
// Added by the designer: the Avalon-MM register port and the address map.
module drive_status_assembly_packer (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         resetn,
    // Drive status from the inverter core
    input  wire asm_pack_pkg::drive_status_t  drive_status,
    // Network side producing request
    input  wire logic                         prod_req,
    input  wire logic [7:0]                   prod_inst,
    output logic                              prod_valid,
    output logic                              prod_err,
    output logic [47:0]                       prod_data,
    output logic [2:0]                        prod_len,
    // Avalon-MM register slave
    input  wire logic [4:0]                   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic [31:0]                       avs_readdata,
    output logic                              avs_waitrequest,
    // Interrupt
    output logic                              irq
);

    // Known instance check, shared by both request sources
    function automatic logic inst_known(input logic [7:0] inst);
        inst_known = (inst == asm_pack_pkg::INST_BASIC)
                  || (inst == asm_pack_pkg::INST_EXT)
                  || (inst == asm_pack_pkg::INST_TORQ)
                  || (inst == asm_pack_pkg::INST_EXT_TORQ);
    endfunction

    // Payload builder, shared by the network and software requests
    function automatic asm_pack_pkg::payload_t build_payload(
        input logic [7:0]                  inst,
        input asm_pack_pkg::drive_status_t st
    );
        logic [7:0] basic_flags;
        logic [7:0] ext_flags;
        asm_pack_pkg::payload_t p;
        basic_flags = 8'h00;
        ext_flags   = 8'h00;
        p           = '0;
        basic_flags[asm_pack_pkg::FLAG_FAULTED_POS] = st.faulted_flag;
        basic_flags[asm_pack_pkg::FLAG_RUN_FWD_POS] = st.running_forward_flag;
        ext_flags[asm_pack_pkg::FLAG_FAULTED_POS]   = st.faulted_flag;
        ext_flags[asm_pack_pkg::FLAG_WARNING_POS]   = st.warning_flag;
        ext_flags[asm_pack_pkg::FLAG_RUN_FWD_POS]   = st.running_forward_flag;
        ext_flags[asm_pack_pkg::FLAG_RUN_REV_POS]   = st.running_reverse_flag;
        ext_flags[asm_pack_pkg::FLAG_READY_POS]     = st.ready_flag;
        ext_flags[asm_pack_pkg::FLAG_CTRL_NET_POS]  = st.ctrl_net_flag;
        ext_flags[asm_pack_pkg::FLAG_REF_NET_POS]   = st.ref_net_flag;
        ext_flags[asm_pack_pkg::FLAG_REACHED_POS]   = st.speed_reached_flag;
        case (inst)
            asm_pack_pkg::INST_BASIC:
            begin
                p.bytes[0] = basic_flags;
                p.bytes[1] = 8'h00;
                p.len      = asm_pack_pkg::LEN_SHORT;
            end
            asm_pack_pkg::INST_EXT:
            begin
                p.bytes[0] = ext_flags;
                p.bytes[1] = st.drive_state;
                p.len      = asm_pack_pkg::LEN_SHORT;
            end
            asm_pack_pkg::INST_TORQ:
            begin
                p.bytes[0] = basic_flags;
                p.bytes[1] = 8'h00;
                p.bytes[4] = st.torque_actual[7:0];
                p.bytes[5] = st.torque_actual[15:8];
                p.len      = asm_pack_pkg::LEN_LONG;
            end
            asm_pack_pkg::INST_EXT_TORQ:
            begin
                p.bytes[0] = ext_flags;
                p.bytes[1] = st.drive_state;
                p.bytes[4] = st.torque_actual[7:0];
                p.bytes[5] = st.torque_actual[15:8];
                p.len      = asm_pack_pkg::LEN_LONG;
            end
            default:
            begin
                p.len      = asm_pack_pkg::LEN_NONE;
            end
        endcase
        if (inst_known(inst))
        begin
            p.bytes[2] = st.speed_actual[7:0];
            p.bytes[3] = st.speed_actual[15:8];
        end
        build_payload = p;
    endfunction

    // Reset synchroniser: async assert, release through two flops
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Register state
    asm_pack_pkg::bus_state_t  bus_q;
    asm_pack_pkg::payload_t    payload_q;
    logic [7:0]                ctrl_inst_q;
    logic                      sw_pending_q;
    logic [7:0]                last_inst_q;
    logic                      last_err_q;
    logic [1:0]                irq_stat_q;
    logic [1:0]                irq_mask_q;
    logic [31:0]               rdata_q;
    logic                      valid_q;
    logic                      err_q;

    // Bus decode
    logic                      bus_req;
    logic                      bus_commit;
    logic                      wr_commit;
    logic                      wr_ctrl;
    logic                      wr_stat;
    logic                      wr_mask;
    logic                      sw_build_wr;

    assign bus_req     = avs_read | avs_write;
    assign bus_commit  = bus_req && (bus_q == asm_pack_pkg::BUS_ACK);
    assign wr_commit   = bus_commit && avs_write;
    assign wr_ctrl     = wr_commit && (avs_address == asm_pack_pkg::REG_CTRL);
    assign wr_stat     = wr_commit && (avs_address == asm_pack_pkg::REG_IRQ_STAT);
    assign wr_mask     = wr_commit && (avs_address == asm_pack_pkg::REG_IRQ_MASK);
    assign sw_build_wr = wr_ctrl && avs_byteenable[1]
                      && avs_writedata[asm_pack_pkg::CTRL_BUILD_POS];

    // Build arbitration: network request wins, a software build waits while prod_req is high
    logic                      build_fire;
    logic                      build_sw;
    logic [7:0]                build_inst;
    logic                      build_ok;
    asm_pack_pkg::payload_t    build_p;

    assign build_sw   = sw_pending_q && !prod_req;
    assign build_fire = prod_req || build_sw;
    assign build_inst = prod_req ? prod_inst : ctrl_inst_q;
    assign build_ok   = inst_known(build_inst);
    // Every field is taken from the same cycle's status word
    assign build_p    = build_payload(build_inst, drive_status);

    // Interrupt events
    logic [1:0]                irq_set;
    logic [1:0]                irq_clr;

    assign irq_set[asm_pack_pkg::IRQ_DONE_POS] = build_fire && build_ok;
    assign irq_set[asm_pack_pkg::IRQ_BAD_POS]  = build_fire && !build_ok;
    assign irq_clr = (wr_stat && avs_byteenable[0]) ? avs_writedata[1:0] : 2'h0;

    // Read mux
    logic [31:0]               rdata_d;

    assign rdata_d =
        (avs_address == asm_pack_pkg::REG_CTRL)       ? {24'h000000, ctrl_inst_q} :
        (avs_address == asm_pack_pkg::REG_STATUS)     ? {23'h000000, last_err_q, last_inst_q} :
        (avs_address == asm_pack_pkg::REG_IRQ_STAT)   ? {30'h00000000, irq_stat_q} :
        (avs_address == asm_pack_pkg::REG_IRQ_MASK)   ? {30'h00000000, irq_mask_q} :
        (avs_address == asm_pack_pkg::REG_PAYLOAD_LO) ? payload_q.bytes[3:0] :
        (avs_address == asm_pack_pkg::REG_PAYLOAD_HI) ?
            {13'h0000, payload_q.len, payload_q.bytes[5:4]} :
        32'h00000000;

    // Bus handshake: one wait cycle, then the access completes
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            bus_q   <= asm_pack_pkg::BUS_IDLE;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            case (bus_q)
                asm_pack_pkg::BUS_IDLE:
                begin
                    if (bus_req)
                    begin
                        bus_q   <= asm_pack_pkg::BUS_ACK;
                        rdata_q <= rdata_d;
                    end
                end
                asm_pack_pkg::BUS_ACK:
                begin
                    bus_q <= asm_pack_pkg::BUS_IDLE;
                end
                default:
                begin
                    bus_q <= asm_pack_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Control registers
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ctrl_inst_q <= asm_pack_pkg::CTRL_INST_RST;
            irq_mask_q  <= asm_pack_pkg::IRQ_MASK_RST;
        end
        else
        begin
            if (wr_ctrl && avs_byteenable[0])
                ctrl_inst_q <= avs_writedata[7:0];
            if (wr_mask && avs_byteenable[0])
                irq_mask_q <= avs_writedata[1:0];
        end
    end

    // Software build request, held until the builder is free
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            sw_pending_q <= 1'b0;
        else
            sw_pending_q <= sw_build_wr || (sw_pending_q && !build_sw);
    end

    // Sticky status: a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            irq_stat_q <= 2'h0;
        else
            irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
    end

    // Payload capture; a bad instance leaves the last good payload in place
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            payload_q   <= '0;
            last_inst_q <= 8'h00;
            last_err_q  <= 1'b0;
            valid_q     <= 1'b0;
            err_q       <= 1'b0;
        end
        else
        begin
            valid_q <= prod_req && build_ok;
            err_q   <= prod_req && !build_ok;
            if (build_fire)
            begin
                last_inst_q <= build_inst;
                last_err_q  <= !build_ok;
                if (build_ok)
                    payload_q <= build_p;
            end
        end
    end

    // Outputs
    assign prod_valid      = valid_q;
    assign prod_err        = err_q;
    assign prod_data       = payload_q.bytes;
    assign prod_len        = payload_q.len;
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = bus_req && (bus_q == asm_pack_pkg::BUS_IDLE);
    assign irq             = |(irq_stat_q & irq_mask_q);

endmodule

/* File: testbench/asm_pack_checker.sv */
// Assertion checker for the drive status assembly packer
module asm_pack_checker (
    // Clock and reset
    input wire logic                        core_clk,
    input wire logic                        resetn,
    // Producing side
    input wire asm_pack_pkg::drive_status_t drive_status,
    input wire logic                        prod_req,
    input wire logic [7:0]                  prod_inst,
    input wire logic                        prod_valid,
    input wire logic                        prod_err,
    input wire logic [47:0]                 prod_data,
    input wire logic [2:0]                  prod_len,
    // Interrupt
    input wire logic                        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire known = prod_req && prod_inst >= 8'h46 && prod_inst <= 8'h49;
    wire ext   = known && prod_inst[0];
    wire torq  = known && prod_inst >= 8'h48;

    good_req_a: assert property (known |=> prod_valid && !prod_err)
        else $error("good request not answered");
    bad_req_a: assert property (prod_req && !known |=> prod_err && !prod_valid)
        else $error("bad request accepted");
    idle_out_a: assert property (!prod_req |=> !prod_valid && !prod_err)
        else $error("answer without request");
    short_len_a: assert property (known && !torq |=> prod_len == 3'h4 && prod_data[47:32] == 16'h0000)
        else $error("short payload wrong");
    long_len_a: assert property (torq |=> prod_len == 3'h6)
        else $error("long payload length wrong");
    speed_pos_a: assert property (known |=> prod_data[31:16] == $past(drive_status.speed_actual))
        else $error("speed bytes wrong");
    torque_pos_a: assert property (torq |=> prod_data[47:32] == $past(drive_status.torque_actual))
        else $error("torque bytes wrong");
    basic_hdr_a: assert property (known && !ext |=> prod_data[15:0] ==
        {13'h0000, $past(drive_status.running_forward_flag), 1'b0, $past(drive_status.faulted_flag)})
        else $error("basic header wrong");
    ext_hdr_a: assert property (ext |=> prod_data[15:0] ==
        {$past(drive_status.drive_state), $past(drive_status[47:40])})
        else $error("extended header wrong");

    cover property (prod_valid && prod_len == 3'h6);
    cover property (prod_valid && prod_len == 3'h4);
    cover property (prod_err);
    cover property (irq);
endmodule

bind drive_status_assembly_packer asm_pack_checker i_chk (
    .core_clk(core_clk), .resetn(resetn), .drive_status(drive_status), .prod_req(prod_req),
    .prod_inst(prod_inst), .prod_valid(prod_valid), .prod_err(prod_err), .prod_data(prod_data),
    .prod_len(prod_len), .irq(irq));

/* File: testbench/net_scanner.sv */
// Network scanner model that issues producing requests
module net_scanner (
    // Clock
    input wire logic   core_clk,
    // Producing request
    output logic       prod_req,
    output logic [7:0] prod_inst
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        prod_req  = 1'b0;
        prod_inst = 8'h5A;
    end

    // Slow scanners idle some cycles; the number is scrambled after release
    // so a stale instance is never mistaken for a fresh one
    task automatic request(input logic [7:0] inst, input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        prod_req  <= 1'b1;
        prod_inst <= inst;
        @(posedge core_clk);
        prod_req  <= 1'b0;
        prod_inst <= ~inst;
    endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking testbench for the drive status assembly packer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        core_clk = 1'b0;
    logic                        resetn = 1'b0;
    asm_pack_pkg::drive_status_t ds = '0;
    logic                        prod_req;
    logic                        prod_valid;
    logic                        prod_err;
    logic                        irq;
    logic                        av_wait;
    logic                        av_rd = 1'b0;
    logic                        av_wr = 1'b0;
    logic [4:0]                  av_addr = 5'h00;
    logic [7:0]                  prod_inst;
    logic [2:0]                  prod_len;
    logic [2:0]                  llen = 3'h0;
    logic [47:0]                 prod_data;
    logic [47:0]                 last = 48'h0;
    logic [31:0]                 av_wd = 32'h0;
    logic [31:0]                 av_rdata;
    logic [31:0]                 rd;
    logic [31:0]                 lfsr = 32'hCCA24FF0;
    int                          miscompares = 0;
    int                          n_checks = 0;
    int                          cyc = 0;

    always #10 core_clk = ~core_clk;

    drive_status_assembly_packer i_dut (
        .core_clk(core_clk), .resetn(resetn), .drive_status(ds), .prod_req(prod_req),
        .prod_inst(prod_inst), .prod_valid(prod_valid), .prod_err(prod_err), .prod_data(prod_data),
        .prod_len(prod_len), .avs_address(av_addr), .avs_read(av_rd), .avs_write(av_wr),
        .avs_writedata(av_wd), .avs_byteenable(4'hF), .avs_readdata(av_rdata),
        .avs_waitrequest(av_wait), .irq(irq));

    net_scanner i_scan (.core_clk(core_clk), .prod_req(prod_req), .prod_inst(prod_inst));

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    function automatic void step();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    endfunction

    function automatic logic [47:0] exp_pay(input logic [7:0] i, input asm_pack_pkg::drive_status_t s);
        logic [7:0]  b0;
        logic [15:0] tq;
        b0 = i[0] ? s[47:40] : {5'h00, s.running_forward_flag, 1'b0, s.faulted_flag};
        tq = (i >= 8'h48) ? s.torque_actual : 16'h0000;
        return {tq, s.speed_actual, i[0] ? s.drive_state : 8'h00, b0};
    endfunction

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Request held until the edge that samples waitrequest low
    // A lost answer is caught by the cycle ceiling, not here
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        av_addr <= a;
        av_wd   <= d;
        av_wr   <= w;
        av_rd   <= !w;
        do
            @(posedge core_clk);
        while (av_wait !== 1'b0);
        rd = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask

    task automatic net(input logic [7:0] i, input int gap);
        asm_pack_pkg::drive_status_t s;
        logic                        good;
        step();
        s[47:16] = lfsr;
        step();
        s[15:0] = lfsr[15:0];
        @(posedge core_clk);
        ds <= s;
        i_scan.request(i, gap);
        @(negedge core_clk);
        good = i >= 8'h46 && i <= 8'h49;
        if (good)
        begin
            last = exp_pay(i, s);
            llen = (i >= 8'h48) ? 3'h6 : 3'h4;
        end
        chk({46'h0, prod_valid, prod_err}, {46'h0, good, !good}, "answer");
        chk(prod_data, last, "payload");
        chk({45'h0, prod_len}, {45'h0, llen}, "length");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({45'h0, prod_len}, 48'h0, "length after reset");
        bus(1'b0, asm_pack_pkg::REG_CTRL, 32'h0);
        chk({16'h0, rd}, 48'h46, "control reset");
        $display("test reset done");
        bus(1'b1, asm_pack_pkg::REG_IRQ_MASK, 32'h3);
        net(8'h45, 0);
        chk({47'h0, irq}, 48'h1, "irq on bad instance");
        bus(1'b0, asm_pack_pkg::REG_STATUS, 32'h0);
        chk({16'h0, rd}, 48'h145, "status");
        bus(1'b1, asm_pack_pkg::REG_IRQ_STAT, 32'h3);
        @(negedge core_clk);
        chk({47'h0, irq}, 48'h0, "irq cleared");
        $display("test irq done");
        // Fixed corner numbers first, then random ones around the valid range
        for (int k = 0; k < 48; k++)
        begin
            step();
            case (k)
                0: net(8'h46, 0);
                1: net(8'h47, 1);
                2: net(8'h48, 0);
                3: net(8'h49, 2);
                4: net(8'h00, 0);
                5: net(8'hFF, 0);
                default: net(8'h44 + {5'h00, lfsr[2:0]}, int'(lfsr[4:3]));
            endcase
        end
        $display("test layouts done");
        bus(1'b0, asm_pack_pkg::REG_PAYLOAD_LO, 32'h0);
        chk({16'h0, rd}, {16'h0, last[31:0]}, "payload low");
        bus(1'b0, asm_pack_pkg::REG_PAYLOAD_HI, 32'h0);
        chk({16'h0, rd}, {29'h0, llen, last[47:32]}, "payload high");
        bus(1'b1, asm_pack_pkg::REG_IRQ_MASK, 32'h0);
        @(negedge core_clk);
        chk({47'h0, irq}, 48'h0, "irq masked");
        bus(1'b1, asm_pack_pkg::REG_CTRL, 32'h149);
        repeat (4) @(posedge core_clk);
        bus(1'b0, asm_pack_pkg::REG_PAYLOAD_LO, 32'h0);
        last = exp_pay(8'h49, ds);
        chk({16'h0, rd}, {16'h0, last[31:0]}, "software build");
        bus(1'b0, asm_pack_pkg::REG_PAYLOAD_HI, 32'h0);
        chk({16'h0, rd}, {29'h0, 3'h6, last[47:32]}, "software build torque");
        bus(1'b0, asm_pack_pkg::REG_STATUS, 32'h0);
        chk({16'h0, rd}, 48'h49, "status after software build");
        bus(1'b0, 5'h18, 32'h0);
        chk({16'h0, rd}, 48'h0, "unmapped read");
        $display("test registers done");
        tally_and_finish();
    end
endmodule
